// >>> rtl/scsd_pkg.sv
// Constants and types shared by the system clock select and divide block
package scsd_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_CONTROL_A    = 8'h00;  // Sub select, stops, divide-by-8
  localparam logic [7:0] OFS_CLOCK_CONTROL_B    = 8'h04;  // Resistor, pins, divider field
  localparam logic [7:0] OFS_OSC_STOP_DETECT    = 8'h08;  // System clock oscillator select
  localparam logic [7:0] OFS_ONCHIP_OSC_CONTROL = 8'h0c;  // On-chip oscillator enables
  localparam logic [7:0] OFS_CLOCK_STATUS       = 8'h10;  // Read-only live state

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SUB_CLOCK_SELECT        = 1;  // In clock_control_a
  localparam int BIT_PERIPH_STOP_IN_WAIT     = 2;  // In clock_control_a
  localparam int BIT_SUB_CLOCK_PIN_FUNCTION  = 4;  // In clock_control_a
  localparam int BIT_MAIN_CLOCK_STOP         = 5;  // In clock_control_a
  localparam int BIT_CPU_DIVIDE_BY_EIGHT     = 6;  // In clock_control_a
  localparam int BIT_SUB_FEEDBACK_RESISTOR   = 2;  // In clock_control_b, 1 = disconnected
  localparam int BIT_MAIN_CLOCK_PIN_FUNCTION = 3;  // In clock_control_b
  localparam int BIT_LOW_SPEED_OSC_CONTROL   = 4;  // In clock_control_b, 0 = on
  localparam int BIT_CPU_DIVIDER_FIELD_LO    = 6;  // In clock_control_b
  localparam int BIT_CPU_DIVIDER_FIELD_HI    = 7;  // In clock_control_b
  localparam int BIT_SYSTEM_CLOCK_OSC_SELECT = 2;  // In osc_stop_detect_reg
  localparam int BIT_HIGH_SPEED_OSC_ENABLE   = 0;  // In onchip_osc_control
  localparam int BIT_ONCHIP_SPEED_SELECT     = 1;  // In onchip_osc_control

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CLOCK_CONTROL_A    = 8'h60;  // Divide-by-8, main stopped
  localparam logic [7:0] RST_CLOCK_CONTROL_B    = 8'h00;
  localparam logic [7:0] RST_OSC_STOP_DETECT    = 8'h04;  // On-chip oscillator selected
  localparam logic [7:0] RST_ONCHIP_OSC_CONTROL = 8'h00;  // Low-speed on-chip chosen

  // ----------------------------------------------------------------------
  // Division ratios
  // ----------------------------------------------------------------------
  localparam int NUM_PRESCALE              = 4;
  localparam int PRESCALE_RATIO [NUM_PRESCALE] = '{2, 4, 8, 32};  // f2, f4, f8, f32
  localparam int CAPTURE_RATIO             = 128;
  localparam int SUB_RTC_RATIO             = 4;
  localparam int SUB_TIMER_RATIO           = 32;
  localparam logic [4:0] CPU_RATIO_DIV8    = 5'h08;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_SUB  = 2'b01,
    SRC_HS   = 2'b10,
    SRC_LS   = 2'b11
  } scsd_src_e;

  typedef enum logic [2:0] {
    MODE_NONE      = 3'b000,
    MODE_HS_CLOCK  = 3'b001,
    MODE_LS_CLOCK  = 3'b010,
    MODE_HS_ONCHIP = 3'b011,
    MODE_LS_ONCHIP = 3'b100
  } scsd_mode_e;

endpackage

// >>> rtl/scsd_tick_div.sv
// Tick divider that emits one registered pulse every RATIO input ticks
`timescale 1ns/10ps
module scsd_tick_div #(
  parameter int RATIO = 2
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic tick_i,    // Source tick, one cycle wide
  input  wire logic gate_i,    // Counting allowed
  output logic      pulse_o    // Divided tick
);

  localparam int CNT_W = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(RATIO - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;  // Ticks seen in this period
    logic             pulse;
  } scsd_div_state_s;

  scsd_div_state_s s_q;
  scsd_div_state_s s_d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    if (tick_i && gate_i) begin
      // Wrap at the last tick of the period
      if (s_q.cnt == LAST) begin
        s_d.cnt   = '0;
        s_d.pulse = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register, cleared so the phase is known at release
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_o = s_q.pulse;

endmodule

// >>> rtl/scsd_top.sv
// System clock source select, CPU divider and derived peripheral clocks
`timescale 1ns/10ps
module scsd_top
  import scsd_pkg::*;
#(
  parameter bit HAS_SUB_OSC = 1'b1  // Variant carries a sub oscillator
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Oscillator ticks, one cycle wide per source period
  input  wire logic        main_crystal_tick_i,
  input  wire logic        sub_crystal_tick_i,
  input  wire logic        hs_osc_tick_i,
  input  wire logic        ls_osc_tick_i,
  // Power state from the CPU
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  // Oscillator controls
  output logic             main_osc_enable_o,
  output logic             sub_osc_enable_o,
  output logic             sub_feedback_connect_o,
  output logic             hs_osc_enable_o,
  output logic             ls_osc_enable_o,
  // Clock enables
  output logic             cpu_clock_o,
  output logic      [4:0]  prescaled_periph_clock_o,  // f1, f2, f4, f8, f32
  output logic             onchip_periph_clock_o,
  output logic             timer_fast_count_clock_o,
  output logic             converter_fast_clock_o,
  output logic             watchdog_slow_clock_o,
  output logic             capture_div128_clock_o,
  output logic             sub_clock_rtc_source_o,
  output logic             sub_clock_timer_source_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cca;        // clock_control_a
    logic [7:0]  ccb;        // clock_control_b
    logic [7:0]  osd;        // osc_stop_detect_reg
    logic [7:0]  ooc;        // onchip_osc_control
    logic        waitreq;    // Avalon waitrequest
    logic [31:0] rdata;      // Avalon read data
    scsd_src_e   act_src;    // Source driving the system clock now
    logic [2:0]  act_div;    // Divide-by-8 bit and field in use now
    logic [3:0]  cpu_cnt;    // System ticks in the current CPU period
    logic        stop_prev;  // Stop input one cycle ago
    scsd_mode_e  mode;       // Decoded standard operating mode
    logic        main_en;
    logic        sub_en;
    logic        fb_con;
    logic        hs_en;
    logic        ls_en;
    logic        cpu_clk;
    logic        f1;
    logic        onchip_periph_clock;
    logic        tfast;
    logic        cfast;
    logic        wslow;
  } scsd_top_state_s;

  scsd_top_state_s s_q;
  scsd_top_state_s s_d;

  logic            sys_tick;     // Ticks of the active system clock
  logic            onchip_periph_clock_tick;    // Ticks of the on-chip clock
  logic            sub_tick;     // Gated sub crystal ticks
  logic            periph_gate;  // Prescaled clocks may run
  logic            boundary;     // Last tick of a CPU period
  logic            src_alive;    // Active source still oscillating
  scsd_src_e       req_src;      // Source that the registers ask for
  logic [2:0]      req_div;      // Divider that the registers ask for
  logic            bus_req;      // Read or write pending
  logic            bus_take;     // Access completes at this edge
  logic [7:0]      wbyte;        // Write lane 0

  // Ratio of a divider code {divide-by-8, field}
  function automatic logic [4:0] cpu_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = CPU_RATIO_DIV8;
    if (!code[2]) begin
      case (code[1:0])
        2'b00:   r = 5'h01;
        2'b01:   r = 5'h02;
        2'b10:   r = 5'h04;
        default: r = 5'h10;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Combinational source and gating terms
  // ----------------------------------------------------------------------
  always_comb begin
    // Crystal path or on-chip clock; sub only on the variant that has it
    if (!s_q.osd[BIT_SYSTEM_CLOCK_OSC_SELECT]) begin
      req_src = (HAS_SUB_OSC && s_q.cca[BIT_SUB_CLOCK_SELECT]) ? SRC_SUB : SRC_MAIN;
    end else begin
      req_src = s_q.ooc[BIT_ONCHIP_SPEED_SELECT] ? SRC_HS : SRC_LS;
    end
    req_div = {s_q.cca[BIT_CPU_DIVIDE_BY_EIGHT],
               s_q.ccb[BIT_CPU_DIVIDER_FIELD_HI], s_q.ccb[BIT_CPU_DIVIDER_FIELD_LO]};
    // Tick and liveness of the source in use
    case (s_q.act_src)
      SRC_MAIN: begin
        sys_tick  = main_crystal_tick_i && s_q.main_en;
        src_alive = s_q.main_en;
      end
      SRC_SUB: begin
        sys_tick  = sub_crystal_tick_i && s_q.sub_en;
        src_alive = s_q.sub_en;
      end
      SRC_HS: begin
        sys_tick  = hs_osc_tick_i && s_q.hs_en;
        src_alive = s_q.hs_en;
      end
      default: begin
        sys_tick  = ls_osc_tick_i && s_q.ls_en;
        src_alive = s_q.ls_en;
      end
    endcase
    sys_tick    = sys_tick && !stop_mode_i;
    onchip_periph_clock_tick   = !stop_mode_i && (s_q.ooc[BIT_ONCHIP_SPEED_SELECT] ?
                  (hs_osc_tick_i && s_q.hs_en) : (ls_osc_tick_i && s_q.ls_en));
    sub_tick    = sub_crystal_tick_i && s_q.sub_en && !stop_mode_i;
    periph_gate = !(wait_mode_i && s_q.cca[BIT_PERIPH_STOP_IN_WAIT]);
    boundary    = sys_tick && (s_q.cpu_cnt == 4'(cpu_ratio(s_q.act_div) - 5'h01));
    bus_req     = avs_read_i || avs_write_i;
    bus_take    = bus_req && !s_q.waitreq;
    wbyte       = avs_writedata_i[7:0];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.stop_prev = stop_mode_i;
    // Bus: one wait cycle, then the access completes
    s_d.waitreq   = !(bus_req && s_q.waitreq);
    if (bus_req && s_q.waitreq && avs_read_i) begin
      case (avs_address_i)
        OFS_CLOCK_CONTROL_A:    s_d.rdata = {24'h000000, s_q.cca};
        OFS_CLOCK_CONTROL_B:    s_d.rdata = {24'h000000, s_q.ccb};
        OFS_OSC_STOP_DETECT:    s_d.rdata = {24'h000000, s_q.osd};
        OFS_ONCHIP_OSC_CONTROL: s_d.rdata = {24'h000000, s_q.ooc};
        OFS_CLOCK_STATUS:       s_d.rdata = {20'h00000, s_q.mode, s_q.act_src,
                                             s_q.main_en, s_q.sub_en, s_q.hs_en,
                                             s_q.ls_en, s_q.fb_con, 2'b00};
        default:                s_d.rdata = 32'h00000000;  // Unmapped reads zero
      endcase
    end
    // Register writes land on lane 0 at the completing edge
    if (bus_take && avs_write_i && avs_byteenable_i[0]) begin
      case (avs_address_i)
        OFS_CLOCK_CONTROL_A:    s_d.cca = wbyte;
        OFS_CLOCK_CONTROL_B:    s_d.ccb = wbyte;
        OFS_OSC_STOP_DETECT:    s_d.osd = wbyte;
        OFS_ONCHIP_OSC_CONTROL: s_d.ooc = wbyte;
        default:                s_d.cca = s_q.cca;  // Unmapped writes ignored
      endcase
    end
    // Stop entry from high-speed clock mode forces divide-by-8; beats a write
    if (stop_mode_i && !s_q.stop_prev && s_q.mode == MODE_HS_CLOCK) begin
      s_d.cca[BIT_CPU_DIVIDE_BY_EIGHT] = 1'b1;
    end
    // Mode decode, don't-care bits left out
    s_d.mode = MODE_NONE;
    if (!s_q.osd[BIT_SYSTEM_CLOCK_OSC_SELECT]) begin
      if (s_q.ccb[BIT_MAIN_CLOCK_PIN_FUNCTION] && !s_q.cca[BIT_MAIN_CLOCK_STOP] &&
          !s_q.cca[BIT_SUB_CLOCK_SELECT]) begin
        s_d.mode = MODE_HS_CLOCK;
      end else if (HAS_SUB_OSC && s_q.cca[BIT_SUB_CLOCK_PIN_FUNCTION] &&
                   s_q.cca[BIT_SUB_CLOCK_SELECT]) begin
        s_d.mode = MODE_LS_CLOCK;
      end
    end else if (s_q.ooc[BIT_ONCHIP_SPEED_SELECT] && s_q.ooc[BIT_HIGH_SPEED_OSC_ENABLE]) begin
      s_d.mode = MODE_HS_ONCHIP;
    end else if (!s_q.ooc[BIT_ONCHIP_SPEED_SELECT] && !s_q.ccb[BIT_LOW_SPEED_OSC_CONTROL]) begin
      s_d.mode = MODE_LS_ONCHIP;
    end
    // Oscillator controls, everything off in stop
    s_d.main_en = !stop_mode_i && s_q.ccb[BIT_MAIN_CLOCK_PIN_FUNCTION] &&
                  !(s_q.cca[BIT_MAIN_CLOCK_STOP] &&
                    s_q.osd[BIT_SYSTEM_CLOCK_OSC_SELECT]);
    s_d.sub_en  = HAS_SUB_OSC && !stop_mode_i && s_q.cca[BIT_SUB_CLOCK_SELECT] &&
                  s_q.cca[BIT_SUB_CLOCK_PIN_FUNCTION];
    s_d.fb_con  = HAS_SUB_OSC && !stop_mode_i &&
                  !s_q.ccb[BIT_SUB_FEEDBACK_RESISTOR];
    s_d.hs_en   = !stop_mode_i && s_q.ooc[BIT_HIGH_SPEED_OSC_ENABLE];
    s_d.ls_en   = !stop_mode_i && !s_q.ccb[BIT_LOW_SPEED_OSC_CONTROL];
    // CPU divider; switch source and ratio at a period boundary, or at once while the active source is disabled
    s_d.cpu_clk = 1'b0;
    if (!src_alive) begin
      // Old source gone: no pulse can be cut short, take the request now
      s_d.act_src = req_src;
      s_d.act_div = req_div;
      s_d.cpu_cnt = 4'h0;
    end else if (boundary) begin
      s_d.cpu_clk = !wait_mode_i;
      s_d.cpu_cnt = 4'h0;
      s_d.act_src = req_src;
      s_d.act_div = req_div;
    end else if (sys_tick) begin
      s_d.cpu_cnt = s_q.cpu_cnt + 4'h1;
    end
    // Derived clocks
    s_d.f1    = sys_tick && periph_gate;
    s_d.onchip_periph_clock  = onchip_periph_clock_tick;
    s_d.tfast = hs_osc_tick_i && s_q.hs_en && !stop_mode_i;
    s_d.cfast = hs_osc_tick_i && s_q.hs_en && !stop_mode_i;
    s_d.wslow = ls_osc_tick_i && s_q.ls_en && !stop_mode_i;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q         <= '0;
      s_q.cca     <= RST_CLOCK_CONTROL_A;
      s_q.ccb     <= RST_CLOCK_CONTROL_B;
      s_q.osd     <= RST_OSC_STOP_DETECT;
      s_q.ooc     <= RST_ONCHIP_OSC_CONTROL;
      s_q.waitreq <= 1'b1;
      s_q.act_src <= SRC_LS;
      s_q.act_div <= 3'b100;
      s_q.mode    <= MODE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaled peripheral clocks f2 to f32
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PRESCALE; i++) begin : g_pre
      scsd_tick_div #(
        .RATIO     (PRESCALE_RATIO[i])
      ) u_div (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .tick_i    (sys_tick),
        .gate_i    (periph_gate),
        .pulse_o   (prescaled_periph_clock_o[i+1])
      );
    end
  endgenerate

  // Capture clock from the on-chip peripheral clock
  scsd_tick_div #(
    .RATIO     (CAPTURE_RATIO)
  ) u_capture (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tick_i    (onchip_periph_clock_tick),
    .gate_i    (1'b1),
    .pulse_o   (capture_div128_clock_o)
  );

  // Sub-derived clocks, held low on variants without the sub oscillator
  scsd_tick_div #(
    .RATIO     (SUB_RTC_RATIO)
  ) u_sub_rtc (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tick_i    (sub_tick),
    .gate_i    (HAS_SUB_OSC),
    .pulse_o   (sub_clock_rtc_source_o)
  );

  scsd_tick_div #(
    .RATIO     (SUB_TIMER_RATIO)
  ) u_sub_tmr (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tick_i    (sub_tick),
    .gate_i    (HAS_SUB_OSC),
    .pulse_o   (sub_clock_timer_source_o)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_readdata_o              = s_q.rdata;
  assign avs_waitrequest_o           = s_q.waitreq;
  assign main_osc_enable_o           = s_q.main_en;
  assign sub_osc_enable_o            = s_q.sub_en;
  assign sub_feedback_connect_o      = s_q.fb_con;
  assign hs_osc_enable_o             = s_q.hs_en;
  assign ls_osc_enable_o             = s_q.ls_en;
  assign cpu_clock_o                 = s_q.cpu_clk;
  assign prescaled_periph_clock_o[0] = s_q.f1;
  assign onchip_periph_clock_o       = s_q.onchip_periph_clock;
  assign timer_fast_count_clock_o    = s_q.tfast;
  assign converter_fast_clock_o      = s_q.cfast;
  assign watchdog_slow_clock_o       = s_q.wslow;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_sub_osc_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sub_osc_enable_o |-> $past(s_q.cca[BIT_SUB_CLOCK_SELECT] &&
                               s_q.cca[BIT_SUB_CLOCK_PIN_FUNCTION]))
    else $error("sub oscillator started without both enable bits");

  a_stop_halts_all: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    stop_mode_i ##1 stop_mode_i |=> !cpu_clock_o && !sub_feedback_connect_o &&
                                    prescaled_periph_clock_o == 5'h00 && !onchip_periph_clock_o)
    else $error("clock or feedback resistor active in stop");

  a_stop_div8_set: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ($rose(stop_mode_i) && s_q.mode == MODE_HS_CLOCK) |=> s_q.cca[BIT_CPU_DIVIDE_BY_EIGHT])
    else $error("divide-by-8 not forced at stop entry");

  a_wait_periph_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(wait_mode_i && s_q.cca[BIT_PERIPH_STOP_IN_WAIT]) |-> prescaled_periph_clock_o == 5'h00)
    else $error("prescaled clock ran in wait with stop bit set");

  a_cpu_ratio: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_clock_o |-> $past(s_q.cpu_cnt) == 4'(cpu_ratio($past(s_q.act_div)) - 5'h01))
    else $error("CPU pulse at wrong divider count");

  a_hs_mode_dec: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!s_q.osd[BIT_SYSTEM_CLOCK_OSC_SELECT] && s_q.ccb[BIT_MAIN_CLOCK_PIN_FUNCTION] &&
     !s_q.cca[BIT_MAIN_CLOCK_STOP] && !s_q.cca[BIT_SUB_CLOCK_SELECT]) |=>
     s_q.mode == MODE_HS_CLOCK)
    else $error("high-speed clock mode not decoded");

  a_fast_clk_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (timer_fast_count_clock_o || converter_fast_clock_o) |->
    ($past(s_q.ooc[BIT_HIGH_SPEED_OSC_ENABLE], 2) && $past(hs_osc_tick_i)))
    else $error("fast clock without high-speed enable");

  a_slow_clk_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    watchdog_slow_clock_o |->
    ($past(!s_q.ccb[BIT_LOW_SPEED_OSC_CONTROL], 2) && $past(ls_osc_tick_i)))
    else $error("watchdog clock with low-speed oscillator off");

  a_main_stop_guard: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!s_q.osd[BIT_SYSTEM_CLOCK_OSC_SELECT] && s_q.ccb[BIT_MAIN_CLOCK_PIN_FUNCTION] &&
     !stop_mode_i) |=> main_osc_enable_o)
    else $error("main crystal stopped while on the crystal path");

endmodule

// >>> dv/scsd_osc_model.sv
// Oscillator model: tick pulses only while each oscillator is enabled
`timescale 1ns/10ps
module scsd_osc_model (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] osc_en_i,  // Main, sub, hs, ls enables
  output logic      [3:0] tick_o     // One-cycle ticks, same order
);
  logic [4:0] cnt_q = '0;  // Free-running phase counter
  initial tick_o = '0;
  // Periods main 4, sub 32, hs 2, ls 4; no tick while stopped
  always @(posedge clk_sys_i) begin
    cnt_q <= cnt_q + 5'h01;
    tick_o <= osc_en_i & {cnt_q[1:0] == 2'h1, cnt_q == 5'h03, cnt_q[0], cnt_q[1:0] == 2'h2};
  end
endmodule

// >>> dv/test_system_clock_select_divide.sv
// Self-checking bench of the clock select and divide block
`timescale 1ns/10ps
module test_system_clock_select_divide;
  import scsd_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk_sys_i, resetn_i, avs_read_i, avs_write_i, wait_mode_i, stop_mode_i, wrq;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, rdata, q;
  logic main_en, sub_en, fb_con, hs_en, ls_en, cpu_clk, oc_clk, cap_clk;
  logic tf_clk, cf_clk, ws_clk, rtc_clk, st_clk;
  logic [3:0] tick;
  logic [4:0] fi;
  int n_mismatch, comparisons, cyc, n_cpu, n_ls, n_f1, n_oc, n_cap;
  int n_hs, n_sub, n_f32, n_tf, n_cf, n_ws, n_rtc, n_st;
  int ratio [4] = '{1, 2, 4, 16};
  scsd_osc_model osc (.clk_sys_i, .osc_en_i({main_en, sub_en, hs_en, ls_en}), .tick_o(tick));
  scsd_top uut (.clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wrq), .main_crystal_tick_i(tick[3]), .sub_crystal_tick_i(tick[2]),
    .hs_osc_tick_i(tick[1]), .ls_osc_tick_i(tick[0]), .wait_mode_i, .stop_mode_i,
    .main_osc_enable_o(main_en), .sub_osc_enable_o(sub_en), .sub_feedback_connect_o(fb_con),
    .hs_osc_enable_o(hs_en), .ls_osc_enable_o(ls_en), .cpu_clock_o(cpu_clk),
    .prescaled_periph_clock_o(fi), .onchip_periph_clock_o(oc_clk),
    .timer_fast_count_clock_o(tf_clk), .converter_fast_clock_o(cf_clk),
    .watchdog_slow_clock_o(ws_clk), .capture_div128_clock_o(cap_clk),
    .sub_clock_rtc_source_o(rtc_clk), .sub_clock_timer_source_o(st_clk));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Pulse counters and hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    n_cpu += cpu_clk; n_ls += tick[0]; n_f1 += fi[0]; n_oc += oc_clk; n_cap += cap_clk;
    n_hs += tick[1]; n_sub += tick[2]; n_f32 += fi[4]; n_tf += tf_clk; n_cf += cf_clk;
    n_ws += ws_clk; n_rtc += rtc_clk; n_st += st_clk;
    if (cyc == 30000) begin n_mismatch++; end_of_test(); end
  end
  // Avalon access, held until waitrequest is sampled low
  task acc(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a; avs_writedata_i <= {24'h0, d}; avs_write_i <= w; avs_read_i <= !w;
    // Only the cycle ceiling ends a wait that never completes
    do begin @(posedge clk_sys_i); end while (wrq !== 1'b0);
    q = rdata;
    avs_write_i <= 1'b0; avs_read_i <= 1'b0;
  endtask
  // Counts pulses over n cycles
  task span(input int n);
    @(negedge clk_sys_i); n_cpu = 0; n_ls = 0; n_f1 = 0; n_oc = 0; n_cap = 0;
    n_hs = 0; n_sub = 0; n_f32 = 0; n_tf = 0; n_cf = 0; n_ws = 0; n_rtc = 0; n_st = 0;
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task end_of_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {resetn_i, avs_read_i, avs_write_i, wait_mode_i, stop_mode_i} = '0;
    avs_address_i = '0; avs_writedata_i = '0;
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    acc(0, OFS_CLOCK_CONTROL_A, 0); `CHK(q, 32'h60)
    acc(0, OFS_OSC_STOP_DETECT, 0); `CHK(q, 32'h04)
    acc(0, 8'h14, 0); `CHK(q, 32'h0)
    `CHK({main_en, sub_en, fb_con, ls_en}, 4'b0011)
    span(100); span(512); `CHK((n_cpu * 8 - n_ls) inside {[-8:8]}, 1'b1)
    `CHK(n_tf + n_cf, 0)
    `CHK((n_ws - n_ls) inside {[-1:1]}, 1'b1)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      acc(1, OFS_CLOCK_CONTROL_B, 8'(k << 6)); acc(1, OFS_CLOCK_CONTROL_A, 8'h20);
      span(100); span(512);
      `CHK((n_cpu * ratio[k] - n_ls) inside {[-ratio[k]:ratio[k]]}, 1'b1)
      `CHK((n_f1 - n_ls) inside {[-1:1]}, 1'b1)
      `CHK((n_f32 * 32 - n_ls) inside {[-32:32]}, 1'b1)
      `CHK((n_oc - n_ls) inside {[-1:1]}, 1'b1)
    end
    $display("test divider done");
    acc(1, OFS_CLOCK_CONTROL_A, 8'h24); wait_mode_i <= 1'b1;
    span(4); span(2048); `CHK(n_f1 + n_f32 + n_cpu, 0)
    `CHK((n_ws - n_ls) inside {[-1:1]}, 1'b1)
    `CHK((n_oc - n_ls) inside {[-1:1]}, 1'b1)
    `CHK((n_cap * 128 - n_oc) inside {[-128:128]}, 1'b1)
    @(posedge clk_sys_i); wait_mode_i <= 1'b0;
    $display("test wait done");
    acc(1, OFS_CLOCK_CONTROL_A, 8'h22); span(4); `CHK(sub_en, 1'b0)
    acc(1, OFS_CLOCK_CONTROL_A, 8'h32); span(4); `CHK(sub_en, 1'b1)
    acc(1, OFS_CLOCK_CONTROL_B, 8'h04); span(4); `CHK(fb_con, 1'b0)
    acc(1, OFS_OSC_STOP_DETECT, 0); span(200); span(1024);
    `CHK(n_cpu inside {[31:33]}, 1'b1)
    `CHK((n_rtc * 4 - n_sub) inside {[-4:4]}, 1'b1)
    `CHK((n_st * 32 - n_sub) inside {[-32:32]}, 1'b1)
    acc(1, OFS_CLOCK_CONTROL_A, 0); acc(1, OFS_CLOCK_CONTROL_B, 8'h08); span(100); span(512);
    `CHK(n_cpu inside {[127:129]}, 1'b1)
    $display("test crystal modes done");
    @(posedge clk_sys_i); stop_mode_i <= 1'b1;
    span(1); span(8);
    `CHK({main_en, sub_en, fb_con, hs_en, ls_en, n_cpu == 0}, 6'h01)
    @(posedge clk_sys_i); stop_mode_i <= 1'b0;
    acc(0, OFS_CLOCK_CONTROL_A, 0); `CHK(q, 32'h40)
    $display("test stop done");
    acc(1, OFS_ONCHIP_OSC_CONTROL, 8'h01); acc(1, OFS_OSC_STOP_DETECT, 8'h04);
    span(100); span(512); `CHK((n_cpu * 8 - n_ls) inside {[-8:8]}, 1'b1)
    `CHK((n_tf - n_hs) inside {[-1:1]}, 1'b1)
    `CHK((n_cf - n_hs) inside {[-1:1]}, 1'b1)
    acc(0, OFS_CLOCK_STATUS, 0); `CHK(q, 32'h9dc)
    $display("test on-chip return done");
    end_of_test();
  end
endmodule
